// [hw/mip_port.sv]
/*
  Matrix accelerator instruction port: takes load, compute and transfer
  instructions from three issue slots, drives storage writes and sequencer
  steps, and keeps the in-order transfer buffer that the host drains.
  Assumes the issuing core shares REF_CLK; A/B/C storage and output
  processing live outside and answer C row reads in the same cycle as the request.
*/
// Behaviour
// - load A writes one 512-bit operand into A storage
// - load A and B sends left operand to A, right to B
// - load B writes one 512-bit operand into B storage
// - load B and C sends left operand to B, right to C
// - load C writes one 512-bit operand into C storage
// - one-cycle latency; accepted only in unprotected mode
// - compute step fires one C sequencer step
// - compute and move also pushes one C row into the buffer
// - compute and move always pushes C data, never a register
// - X sequencer picks the C row for each C row push
// - transfer immediate selects C row or one of four registers
// - register pushes skip X sequencer and output processing
// - transfer buffer is strictly first in, first out
// - initialise sequencers before any load, compute or transfer
// - X sequencer advances once per C row push only
// - push without space raises an overflow error
// - receive pops the oldest entry unchanged
`timescale 1ns/1ps
module mip_port
  import mip_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic UNPROT_MODE,
  input wire logic LD_VALID,
  input wire mip_ld_e LD_OP,
  input wire logic [VEC_W-1:0] LD_SRC1,
  input wire logic [VEC_W-1:0] LD_SRC2,
  input wire logic CM_VALID,
  input wire mip_cm_e CM_OP,
  input wire logic XF_VALID,
  input wire logic [3:0] XF_IMM,
  input wire logic RCV_VALID,
  output logic [VEC_W-1:0] RCV_DATA,
  output logic RCV_DATA_VALID,
  output logic A_WE,
  output logic [VEC_W-1:0] A_WDATA,
  output logic B_WE,
  output logic [VEC_W-1:0] B_WDATA,
  output logic C_WE,
  output logic [VEC_W-1:0] C_WDATA,
  output logic C_STEP,
  output logic [1:0] X_RD_EN,
  output logic [7:0] X_RD_ROW0,
  output logic [7:0] X_RD_ROW1,
  input wire logic [VEC_W-1:0] C_ROW_DATA0,
  input wire logic [VEC_W-1:0] C_ROW_DATA1
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mip_ps_e st;
    logic [31:0] cfg;
    logic [31:0] ofs;
    logic ovf;
    logic ill;
    logic unf;
    logic [7:0] x_row;
    logic [7:0] x_cnt;
    logic [TB_AW-1:0] wr_ptr;
    logic [TB_AW-1:0] rd_ptr;
    logic [TB_CW-1:0] cnt;
    logic [LANES-1:0] pend_v;
    logic [LANES-1:0] pend_c;
    logic [LANES-1:0][SNAP_W-1:0] pend_snap;
    logic a_we;
    logic b_we;
    logic c_we;
    logic c_step;
    logic [VEC_W-1:0] a_wd;
    logic [VEC_W-1:0] b_wd;
    logic [VEC_W-1:0] c_wd;
    logic [LANES-1:0] x_rd_en;
    logic [LANES-1:0][7:0] x_rd_row;
    logic rcv_v;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mip_st_s;

  mip_st_s s_reg;
  mip_st_s s_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    case (a)
      OFS_CONFIG: reg_sel = SEL_CONFIG;
      OFS_OFFSET: reg_sel = SEL_OFFSET;
      OFS_STATUS: reg_sel = SEL_STATUS;
      OFS_BUSY: reg_sel = SEL_BUSY;
      OFS_CTRL: reg_sel = SEL_CTRL;
      default: reg_sel = SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] status_word(input mip_st_s s);
    status_word = '0;
    status_word[ST_OPEN_BIT] = (s.st == PS_OPEN);
    status_word[ST_OVF_BIT] = s.ovf;
    status_word[ST_ILL_BIT] = s.ill;
    status_word[ST_UNF_BIT] = s.unf;
    status_word[ST_XROW_LSB +: 8] = s.x_row;
    status_word[ST_XCNT_LSB +: 8] = s.x_cnt;
    status_word[ST_FILL_LSB +: TB_CW] = s.cnt;
  endfunction

  function automatic logic [31:0] busy_word(input mip_st_s s);
    busy_word = '0;
    busy_word[BSY_NEMPTY_BIT] = (s.cnt != '0);
    busy_word[BSY_FULL_BIT] = (s.cnt == TB_CW'(TB_DEPTH));
    busy_word[BSY_PEND_BIT] = (s.pend_v != '0);
  endfunction

  function automatic logic [31:0] reg_word(input logic [2:0] sel, input mip_st_s s);
    case (sel)
      SEL_CONFIG: reg_word = s.cfg;
      SEL_OFFSET: reg_word = s.ofs;
      SEL_STATUS: reg_word = status_word(s);
      SEL_BUSY: reg_word = busy_word(s);
      default: reg_word = '0;
    endcase
  endfunction

  // one X sequencer step: next row, wrap back to the start row each period
  function automatic logic [15:0] x_adv(input logic [7:0] row, input logic [7:0] cnt,
                                        input logic [31:0] cfg);
    if (cnt == 8'h01)
    begin
      x_adv = {cfg[CFG_COFS_LSB +: 8], cfg[CFG_PER_LSB +: 8]};
    end
    else
    begin
      x_adv = {8'(row + 8'h01), 8'(cnt - 8'h01)};
    end
  endfunction

  // ----------------------------------------------------------------
  // transfer buffer write lanes
  // ----------------------------------------------------------------
  logic acc;
  logic [LANES-1:0][VEC_W-1:0] c_row;
  logic [LANES-1:0][VEC_W-1:0] push_data;
  logic [TB_CW-1:0] free;
  logic we0;
  logic we1;
  logic pop;
  logic [VEC_W-1:0] mem_rd;

  assign acc = (s_reg.st == PS_OPEN) && UNPROT_MODE;
  assign c_row[0] = C_ROW_DATA0;
  assign c_row[1] = C_ROW_DATA1;
  assign free = TB_CW'(TB_DEPTH) - s_reg.cnt;

  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++)
    begin : g_lane
      // snapshots bypass output processing: the raw word sits in the low bits
      assign push_data[gl] = s_reg.pend_c[gl] ? c_row[gl] : {{(VEC_W-SNAP_W){1'b0}}, s_reg.pend_snap[gl]};
    end
  endgenerate

  // lane 0 (compute slot) is older than lane 1 within a packet
  assign we0 = s_reg.pend_v[0] && (free != '0);
  assign we1 = s_reg.pend_v[1] && (free > TB_CW'(we0));
  assign pop = RCV_VALID && acc && (s_reg.cnt != '0);

  mip_tbuf_mem u_tbuf (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .we0(we0),
    .wa0(s_reg.wr_ptr),
    .wd0(push_data[0]),
    .we1(we1),
    .wa1(TB_AW'(s_reg.wr_ptr + TB_AW'(we0))),
    .wd1(push_data[1]),
    .re(pop),
    .ra(s_reg.rd_ptr),
    .rd(mem_rd)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [2:0] sel;
    logic [15:0] xa;
    sel = reg_sel(PADDR);
    xa = '0;
    s_next = s_reg;
    s_next.a_we = 1'b0;
    s_next.b_we = 1'b0;
    s_next.c_we = 1'b0;
    s_next.c_step = 1'b0;
    s_next.x_rd_en = '0;
    s_next.pend_v = '0;
    s_next.pend_c = '0;
    s_next.rcv_v = pop;

    // apb: one wait state, write lands on the edge that sees pready
    s_next.pready = PSEL && PENABLE && !s_reg.pready;
    if (PSEL && PENABLE && !s_reg.pready)
    begin
      s_next.prdata = PWRITE ? 32'h0000_0000 : reg_word(sel, s_reg);
      s_next.pslverr = (sel == SEL_NONE);
    end
    if (PSEL && PENABLE && s_reg.pready && PWRITE)
    begin
      case (sel)
        SEL_CONFIG: s_next.cfg = PWDATA;
        SEL_OFFSET: s_next.ofs = PWDATA;
        SEL_CTRL:
        begin
          if (PWDATA[CTL_CLR_BIT])
          begin
            s_next.ovf = 1'b0;
            s_next.ill = 1'b0;
            s_next.unf = 1'b0;
          end
          // initialisation loads the X sequencer from the live config
          if (PWDATA[CTL_OPEN_BIT])
          begin
            s_next.st = PS_OPEN;
            s_next.x_row = s_reg.cfg[CFG_COFS_LSB +: 8];
            s_next.x_cnt = s_reg.cfg[CFG_PER_LSB +: 8];
          end
        end
        default: s_next.st = s_reg.st;
      endcase
    end

    // instructions out of mode or before initialisation are dropped and flagged
    if ((LD_VALID || CM_VALID || XF_VALID || RCV_VALID) && !acc)
    begin
      s_next.ill = 1'b1;
    end

    if (LD_VALID && acc)
    begin
      case (LD_OP)
        LD_A:
        begin
          s_next.a_we = 1'b1;
          s_next.a_wd = LD_SRC1;
        end
        LD_AB:
        begin
          s_next.a_we = 1'b1;
          s_next.a_wd = LD_SRC1;
          s_next.b_we = 1'b1;
          s_next.b_wd = LD_SRC2;
        end
        LD_B:
        begin
          s_next.b_we = 1'b1;
          s_next.b_wd = LD_SRC1;
        end
        LD_BC:
        begin
          s_next.b_we = 1'b1;
          s_next.b_wd = LD_SRC1;
          s_next.c_we = 1'b1;
          s_next.c_wd = LD_SRC2;
        end
        LD_C:
        begin
          s_next.c_we = 1'b1;
          s_next.c_wd = LD_SRC1;
        end
        default: s_next.ill = 1'b1;
      endcase
    end

    if (CM_VALID && acc)
    begin
      s_next.c_step = 1'b1;
      if (CM_OP == CM_MOVE)
      begin
        s_next.x_rd_en[0] = 1'b1;
        s_next.x_rd_row[0] = s_next.x_row;
        s_next.pend_v[0] = 1'b1;
        s_next.pend_c[0] = 1'b1;
        xa = x_adv(s_next.x_row, s_next.x_cnt, s_reg.cfg);
        s_next.x_row = xa[15:8];
        s_next.x_cnt = xa[7:0];
      end
    end

    if (XF_VALID && acc)
    begin
      case (XF_IMM)
        XF_CROW:
        begin
          s_next.x_rd_en[1] = 1'b1;
          s_next.x_rd_row[1] = s_next.x_row;
          s_next.pend_v[1] = 1'b1;
          s_next.pend_c[1] = 1'b1;
          xa = x_adv(s_next.x_row, s_next.x_cnt, s_reg.cfg);
          s_next.x_row = xa[15:8];
          s_next.x_cnt = xa[7:0];
        end
        XF_CFG, XF_OFS, XF_STAT, XF_BUSY:
        begin
          s_next.pend_v[1] = 1'b1;
          s_next.pend_snap[1] = reg_word(SEL_CONFIG + 3'(XF_IMM[1:0]), s_reg);
        end
        default: s_next.ill = 1'b1;
      endcase
    end

    // a push that finds no room is lost but never reorders the rest
    if ((s_reg.pend_v[0] && !we0) || (s_reg.pend_v[1] && !we1))
    begin
      s_next.ovf = 1'b1;
    end
    if (RCV_VALID && acc && (s_reg.cnt == '0))
    begin
      s_next.unf = 1'b1;
    end
    s_next.wr_ptr = TB_AW'(s_reg.wr_ptr + TB_AW'(we0) + TB_AW'(we1));
    s_next.rd_ptr = TB_AW'(s_reg.rd_ptr + TB_AW'(pop));
    s_next.cnt = TB_CW'(s_reg.cnt + TB_CW'(we0) + TB_CW'(we1) - TB_CW'(pop));
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      s_reg <= '0;
      s_reg.cfg <= CONFIG_RST;
      s_reg.ofs <= OFFSET_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA = s_reg.prdata;
  assign PREADY = s_reg.pready;
  assign PSLVERR = s_reg.pslverr;
  assign RCV_DATA = mem_rd;
  assign RCV_DATA_VALID = s_reg.rcv_v;
  assign A_WE = s_reg.a_we;
  assign A_WDATA = s_reg.a_wd;
  assign B_WE = s_reg.b_we;
  assign B_WDATA = s_reg.b_wd;
  assign C_WE = s_reg.c_we;
  assign C_WDATA = s_reg.c_wd;
  assign C_STEP = s_reg.c_step;
  assign X_RD_EN = s_reg.x_rd_en;
  assign X_RD_ROW0 = s_reg.x_rd_row[0];
  assign X_RD_ROW1 = s_reg.x_rd_row[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_load_a_route: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (LD_VALID && acc && LD_OP == LD_A) |=> (A_WE && !B_WE && !C_WE && A_WDATA == $past(LD_SRC1)))
    else $error("load A did not reach A storage");
  a_load_ab_route: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (LD_VALID && acc && LD_OP == LD_AB) |=> (A_WE && B_WE && A_WDATA == $past(LD_SRC1) && B_WDATA == $past(LD_SRC2)))
    else $error("load A and B misrouted");
  a_load_b_route: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (LD_VALID && acc && LD_OP == LD_B) |=> (B_WE && !A_WE && B_WDATA == $past(LD_SRC1)))
    else $error("load B did not reach B storage");
  a_load_bc_route: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (LD_VALID && acc && LD_OP == LD_BC) |=> (B_WE && C_WE && B_WDATA == $past(LD_SRC1) && C_WDATA == $past(LD_SRC2)))
    else $error("load B and C misrouted");
  a_load_c_route: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (LD_VALID && acc && LD_OP == LD_C) |=> (C_WE && !B_WE && C_WDATA == $past(LD_SRC1)))
    else $error("load C did not reach C storage");
  a_closed_ignore: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !acc |=> (!A_WE && !B_WE && !C_WE && !C_STEP && X_RD_EN == 2'b00))
    else $error("instruction acted outside the accepted mode");
  a_step_move: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (CM_VALID && acc && CM_OP == CM_MOVE) |=> (C_STEP && X_RD_EN[0]) ##1 (RCV_DATA_VALID || s_reg.cnt != '0 || s_reg.ovf))
    else $error("compute and move failed to step and push");
  a_xrow_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (s_next.x_rd_en == 2'b00 && !(PSEL && PENABLE && s_reg.pready && PWRITE)) |=> $stable(s_reg.x_row))
    else $error("X sequencer moved without a C row push");
  a_snap_no_x: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (XF_VALID && acc && XF_IMM[3] && !CM_VALID) |=> (X_RD_EN == 2'b00 && !s_reg.pend_c[1]))
    else $error("register push touched the X sequencer");
  a_ovf_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (s_reg.pend_v != '0 && s_reg.cnt == TB_CW'(TB_DEPTH)) |=> s_reg.ovf)
    else $error("overflow not flagged");
  a_rcv_answer: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (RCV_VALID && acc && s_reg.cnt != '0) |=> RCV_DATA_VALID ##1 !RCV_DATA_VALID || $past(pop))
    else $error("receive did not answer in one cycle");

endmodule // mip_port

// [hw/mip_pkg.sv]
/*
  Shared constants and types for the matrix accelerator instruction port:
  register offsets, field positions, reset values, opcode encodings and sizes.
  Assumes a 100 MHz core clock shared with the issuing vector core.
*/
package mip_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int VEC_W = 512;
  localparam int SNAP_W = 32;
  localparam int TB_DEPTH = 8;
  localparam int TB_AW = 3;
  localparam int TB_CW = 4;
  localparam int LANES = 2;
  localparam int ISSUE_LATENCY_CYC = 1;

  // ----------------------------------------------------------------
  // register map (byte offsets on the APB port)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_OFFSET = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BUSY = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;

  localparam logic [2:0] SEL_CONFIG = 3'h0;
  localparam logic [2:0] SEL_OFFSET = 3'h1;
  localparam logic [2:0] SEL_STATUS = 3'h2;
  localparam logic [2:0] SEL_BUSY = 3'h3;
  localparam logic [2:0] SEL_CTRL = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_COFS_LSB = 0;
  localparam int CFG_PER_LSB = 8;
  localparam int ST_OPEN_BIT = 0;
  localparam int ST_OVF_BIT = 1;
  localparam int ST_ILL_BIT = 2;
  localparam int ST_UNF_BIT = 3;
  localparam int ST_XROW_LSB = 8;
  localparam int ST_XCNT_LSB = 16;
  localparam int ST_FILL_LSB = 24;
  localparam int BSY_NEMPTY_BIT = 0;
  localparam int BSY_FULL_BIT = 1;
  localparam int BSY_PEND_BIT = 2;
  localparam int CTL_OPEN_BIT = 0;
  localparam int CTL_CLR_BIT = 1;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0100;
  localparam logic [31:0] OFFSET_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LD_A = 3'h0,
    LD_AB = 3'h1,
    LD_B = 3'h2,
    LD_BC = 3'h3,
    LD_C = 3'h4
  } mip_ld_e;

  typedef enum logic {
    CM_STEP = 1'b0,
    CM_MOVE = 1'b1
  } mip_cm_e;

  typedef enum logic {
    PS_CLOSED = 1'b0,
    PS_OPEN = 1'b1
  } mip_ps_e;

  localparam logic [3:0] XF_CROW = 4'h0;
  localparam logic [3:0] XF_CFG = 4'h8;
  localparam logic [3:0] XF_OFS = 4'h9;
  localparam logic [3:0] XF_STAT = 4'hA;
  localparam logic [3:0] XF_BUSY = 4'hB;

endpackage

// [hw/mip_tbuf_mem.sv]
/*
  Transfer buffer storage: two write ports (one per pushing lane) and one
  registered read port. Assumes the owner never reads an entry in the cycle
  it is written and keeps its own pointers.
*/
`timescale 1ns/1ps
module mip_tbuf_mem
  import mip_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we0,
  input wire logic [TB_AW-1:0] wa0,
  input wire logic [VEC_W-1:0] wd0,
  input wire logic we1,
  input wire logic [TB_AW-1:0] wa1,
  input wire logic [VEC_W-1:0] wd1,
  input wire logic re,
  input wire logic [TB_AW-1:0] ra,
  output logic [VEC_W-1:0] rd
);

  typedef struct packed {
    logic [TB_DEPTH-1:0][VEC_W-1:0] mem;
    logic [VEC_W-1:0] rd;
  } mip_mem_s;

  mip_mem_s s_reg;
  mip_mem_s s_next;

  always_comb
  begin
    s_next = s_reg;
    if (we0)
    begin
      s_next.mem[wa0] = wd0;
    end
    // lane 1 is the younger push, so it lands after lane 0
    if (we1)
    begin
      s_next.mem[wa1] = wd1;
    end
    if (re)
    begin
      s_next.rd = s_reg.mem[ra];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign rd = s_reg.rd;

endmodule // mip_tbuf_mem

// [tb/mip_crow_model.sv]
/*
  C storage stand-in that answers the port's processed row reads.
  Assumes the port takes the row data at the edge that ends the cycle in which
  it holds the read enable high.
*/
`timescale 1ns/1ps
module mip_crow_model
  import mip_pkg::*;
(
  input wire logic [1:0] rd_en,
  input wire logic [7:0] row0,
  input wire logic [7:0] row1,
  output logic [VEC_W-1:0] data0,
  output logic [VEC_W-1:0] data1
);
  // the row number fills every byte; with no read the lines show the inverse
  // so a stale or early sample can never pass for a fresh row
  always_comb
  begin
    data0 = rd_en[0] ? {64{row0}} : ~{64{row0}};
    data1 = rd_en[1] ? {64{row1}} : ~{64{row1}};
  end
endmodule // mip_crow_model

// [tb/testbench.sv]
/*
  Self-checking bench for the instruction port: APB set-up, slot issue, transfer buffer order.
  Assumes the C storage stand-in mip_crow_model and one 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench
  import mip_pkg::*;
;
  logic REF_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, err;
  logic [7:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd, s;
  logic PREADY, PSLVERR, RCV_DATA_VALID, A_WE, B_WE, C_WE, C_STEP;
  logic UNPROT_MODE = 1, LD_VALID = 0, CM_VALID = 0, XF_VALID = 0, RCV_VALID = 0;
  mip_ld_e LD_OP = LD_A;
  mip_cm_e CM_OP = CM_STEP;
  logic [3:0] XF_IMM = '0;
  logic [VEC_W-1:0] LD_SRC1 = '0, LD_SRC2 = '0, RCV_DATA, A_WDATA, B_WDATA, C_WDATA, C_ROW_DATA0, C_ROW_DATA1;
  logic [1:0] X_RD_EN;
  logic [7:0] X_RD_ROW0, X_RD_ROW1;
  int errors = 0, samples_checked = 0, cyc = 0;
  // rows: {load code, expected A/B/C strobes}
  logic [5:0] ld_tab [5] = '{6'h04, 6'h0E, 6'h12, 6'h1B, 6'h21};
  logic [3:0] xf_tab [4] = '{XF_CFG, XF_OFS, XF_STAT, XF_BUSY};

  always #5 REF_CLK = ~REF_CLK;

  mip_port u_dut (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .UNPROT_MODE, .LD_VALID, .LD_OP, .LD_SRC1, .LD_SRC2, .CM_VALID, .CM_OP, .XF_VALID, .XF_IMM, .RCV_VALID,
    .RCV_DATA, .RCV_DATA_VALID, .A_WE, .A_WDATA, .B_WE, .B_WDATA, .C_WE, .C_WDATA, .C_STEP, .X_RD_EN,
    .X_RD_ROW0, .X_RD_ROW1, .C_ROW_DATA0, .C_ROW_DATA1);
  mip_crow_model u_crow (.rd_en(X_RD_EN), .row0(X_RD_ROW0), .row1(X_RD_ROW1),
    .data0(C_ROW_DATA0), .data1(C_ROW_DATA1));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [VEC_W-1:0] got, input logic [VEC_W-1:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // no fixed wait count: the access phase lasts until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1;
    do
      @(posedge REF_CLK);
    while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask

  // inputs were set at the previous edge; look 1 ns after the take edge
  task automatic fire();
    @(posedge REF_CLK);
    LD_VALID <= 0;
    CM_VALID <= 0;
    XF_VALID <= 0;
    RCV_VALID <= 0;
    #1;
  endtask

  task automatic pop(input logic [VEC_W-1:0] exp, input logic use_exp);
    @(posedge REF_CLK);
    RCV_VALID <= 1;
    fire();
    chk(RCV_DATA_VALID, 1'b1, "pop valid");
    if (use_exp)
      chk(RCV_DATA, exp, "pop data");
  endtask

  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      $display("MISMATCH t=%0t timeout", $time);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge REF_CLK);
    RST_N <= 1;
    apb(0, OFS_CONFIG, 0);
    chk(rd, CONFIG_RST, "config reset");
    apb(0, OFS_OFFSET, 0);
    chk(rd, OFFSET_RST, "offset reset");
    apb(1, 8'h14, 32'h0000_1234);
    chk(err, 1'b1, "unmapped");
    // closed port must refuse loads and flag it
    @(posedge REF_CLK);
    LD_VALID <= 1;
    fire();
    chk(A_WE, 1'b0, "load while closed");
    apb(0, OFS_STATUS, 0);
    chk(rd[ST_ILL_BIT], 1'b1, "ill flag");
    apb(1, OFS_CONFIG, 32'h0000_0203);
    apb(1, OFS_OFFSET, 32'h0000_00A5);
    apb(1, OFS_CTRL, 32'h0000_0003);
    apb(0, OFS_STATUS, 0);
    chk(rd[2:0], 3'h1, "open status");
    for (int i = 0; i < 5; i++)
    begin
      s = 32'h1111_0000 + i;
      @(posedge REF_CLK);
      LD_VALID <= 1;
      LD_OP <= mip_ld_e'(ld_tab[i][5:3]);
      LD_SRC1 <= {16{s}};
      LD_SRC2 <= {16{~s}};
      fire();
      chk({A_WE, B_WE, C_WE}, ld_tab[i][2:0], "load strobes");
      if (A_WE === 1'b1)
        chk(A_WDATA, {16{s}}, "a data");
      if (B_WE === 1'b1)
        chk(B_WDATA, (i == 1) ? {16{~s}} : {16{s}}, "b data");
      if (C_WE === 1'b1)
        chk(C_WDATA, (i == 3) ? {16{~s}} : {16{s}}, "c data");
      @(posedge REF_CLK);
      #1;
      chk({A_WE, B_WE, C_WE}, 3'h0, "strobe pulse");
    end
    // protected mode refuses the load and compute slots
    @(posedge REF_CLK);
    UNPROT_MODE <= 0;
    LD_VALID <= 1;
    CM_VALID <= 1;
    fire();
    chk({A_WE, C_STEP}, 2'h0, "protected mode");
    @(posedge REF_CLK);
    UNPROT_MODE <= 1;
    apb(1, OFS_CTRL, 32'h0000_0002);
    // one packet in all three slots; the reserved compute operand has no port
    @(posedge REF_CLK);
    LD_VALID <= 1;
    LD_OP <= LD_AB;
    CM_VALID <= 1;
    CM_OP <= CM_MOVE;
    XF_VALID <= 1;
    XF_IMM <= XF_CROW;
    fire();
    chk({A_WE, B_WE, C_STEP, X_RD_EN}, 5'h1F, "packet");
    chk({X_RD_ROW0, X_RD_ROW1}, 16'h0304, "x rows");
    foreach (xf_tab[i])
    begin
      @(posedge REF_CLK);
      XF_VALID <= 1;
      XF_IMM <= xf_tab[i];
      fire();
      chk(X_RD_EN, 2'h0, "snapshot push");
    end
    @(posedge REF_CLK);
    CM_VALID <= 1;
    CM_OP <= CM_STEP;
    fire();
    chk({C_STEP, X_RD_EN}, 3'h4, "plain step");
    @(posedge REF_CLK);
    XF_VALID <= 1;
    XF_IMM <= XF_CROW;
    fire();
    chk({X_RD_EN, X_RD_ROW1}, 10'h203, "row wrap");
    repeat (2) @(posedge REF_CLK);
    pop({64{8'h03}}, 1);
    pop({64{8'h04}}, 1);
    pop(VEC_W'(32'h0000_0203), 1);
    pop(VEC_W'(32'h0000_00A5), 1);
    // status at its issue edge: open, row 3, count 2, four entries held
    pop(VEC_W'(32'h0402_0301), 1);
    // busy at its issue edge: not empty, not full, nothing pending
    pop(VEC_W'(32'h0000_0001), 1);
    pop({64{8'h03}}, 1);
    // empty buffer: nothing comes out
    @(posedge REF_CLK);
    RCV_VALID <= 1;
    fire();
    chk(RCV_DATA_VALID, 1'b0, "empty pop");
    // nine pushes into eight places
    @(posedge REF_CLK);
    XF_VALID <= 1;
    XF_IMM <= XF_CFG;
    repeat (8) @(posedge REF_CLK);
    fire();
    repeat (2) @(posedge REF_CLK);
    apb(0, OFS_STATUS, 0);
    chk(rd[ST_OVF_BIT], 1'b1, "overflow");
    chk(rd[ST_UNF_BIT], 1'b1, "underflow");
    apb(0, OFS_BUSY, 0);
    chk(rd[BSY_FULL_BIT], 1'b1, "full");
    pop(VEC_W'(32'h0000_0203), 1);
    // reset in mid-run: outputs drop, the port closes, flags and buffer clear
    @(posedge REF_CLK);
    RST_N <= 0;
    repeat (2) @(posedge REF_CLK);
    chk({A_WE, B_WE, C_WE, C_STEP, X_RD_EN, RCV_DATA_VALID, PREADY}, '0, "outputs in reset");
    RST_N <= 1;
    apb(0, OFS_STATUS, 0);
    chk(rd, 32'h0000_0000, "status after reset");
    apb(0, OFS_BUSY, 0);
    chk(rd, 32'h0000_0000, "busy after reset");
    give_verdict();
  end
endmodule // testbench
